//--- hpsi_addr_decode.sv
/*
  Upper address decoder: turns the three top address bits into the
  self select, the five external selects and the reserved flag.
  Assumes the select input and address are synchronous to the clock.
*/
`timescale 1ns/100ps
module hpsi_addr_decode
  import hpsi_pkg::*;
(
  input  wire logic         sel_n,
  input  wire logic [2:0]   upper,
  output hpsi_decode_t      dec
);

  always_comb begin
    dec = '0;
    case (upper)
      UC_SELF:     dec.self_sel = 1'b1;
      UC_EXT1:     dec.ext_sel  = 5'h01;
      UC_EXT2:     dec.ext_sel  = 5'h02;
      UC_EXT3:     dec.ext_sel  = 5'h04;
      UC_EXT4:     dec.ext_sel  = 5'h08;
      UC_EXT5:     dec.ext_sel  = 5'h10;
      UC_ALL: begin
        dec.self_sel = 1'b1;
        dec.ext_sel  = 5'h1f;
      end
      UC_RESERVED: dec.reserved = 1'b1;
      default:     dec = '0;
    endcase
    // Nothing is selected while the port select is high
    if (sel_n) begin
      dec = '0;
    end
  end

endmodule

//--- hpsi_host_model.sv
/*
  Behavioural host processor on the parallel port, one access per call.
  Assumes the caller is in tb_top; all pin changes follow a rising clk edge.
*/
`timescale 1ns/100ps
module hpsi_host_model
  import hpsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe_n,
  input  wire logic        access_done_ack,
  input  wire logic [4:0]  ext_n,
  input  wire logic        host_irq_out,
  input  wire logic        host_irq_oe_n,
  output logic             sel_n,
  output logic      [10:0] addr,
  output logic      [7:0]  data_in,
  output logic             hp_wr_rw,
  output logic             hp_rd_we,
  output logic             addr_latch_xfer_start,
  output logic             host_bus_clk,
  output logic      [2:0]  host_type_select,
  output logic             int_pin
);
  logic [7:0] hdata;

  assign data_in = data_oe_n ? hdata : data_out;
  // Open-drain line with a pull-up
  assign int_pin = host_irq_oe_n ? 1'b1 : host_irq_out;

  initial begin
    sel_n = 1'b1;
    addr = 11'h000;
    hdata = 8'h00;
    hp_wr_rw = 1'b1;
    hp_rd_we = 1'b1;
    addr_latch_xfer_start = 1'b0;
    host_bus_clk = 1'b0;
    host_type_select = HT_ASYNC_STROBE;
  end

  // Strobes are held a fixed eight cycles; the ack is sampled at each edge meanwhile
  task automatic acc(input logic [2:0] m, input logic [10:0] a, input logic [7:0] wd,
                     input logic rd, input logic cs, output logic [7:0] rdat,
                     output logic got, output logic [4:0] seen);
    @(posedge clk);
    host_type_select <= m;
    @(posedge clk);
    sel_n <= !cs;
    addr <= a;
    hdata <= wd;
    hp_wr_rw <= rd;
    hp_rd_we <= (m == HT_ASYNC_STROBE) ? !rd : (m == HT_SYNC);
    addr_latch_xfer_start <= (m == HT_SYNC);
    host_bus_clk <= (m == HT_SYNC);
    got = 1'b0;
    rdat = 8'h00;
    // Ack and read data are taken at the rising edge, as the port itself samples
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (i == 0) seen = ext_n;
      if (access_done_ack === 1'b1 && !got) begin
        got = 1'b1;
        rdat = data_in;
      end
    end
    hp_wr_rw <= 1'b1;
    hp_rd_we <= 1'b1;
    addr_latch_xfer_start <= 1'b0;
    host_bus_clk <= 1'b0;
    // Released bus shows the inverse so a stale value cannot pass
    hdata <= ~wd;
    @(posedge clk);
    sel_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule

//--- hpsi_host_port.sv
/*
  Host parallel port: select and upper address decode, register access
  forwarding, alarm interrupt with global enable, and an Avalon-MM slave
  for local control and status. All host pins are sampled on clk; the
  host bus clock is an ordinary input whose rising edge is detected.
*/
`timescale 1ns/100ps
module hpsi_host_port
  import hpsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        host_reset_n,
  input  wire logic        sel_n,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n,
  input  wire logic        hp_wr_rw,
  input  wire logic        hp_rd_we,
  input  wire logic        addr_latch_xfer_start,
  input  wire logic        host_bus_clk,
  input  wire logic [2:0]  host_type_select,
  output logic             access_done_ack,
  output logic             host_irq_out,
  output logic             host_irq_oe_n,
  output logic             ext_select_out_1_n,
  output logic             ext_select_out_2_n,
  output logic             ext_select_out_3_n,
  output logic             ext_select_out_4_n,
  output logic             ext_select_out_5_n,
  input  wire logic [7:0]  alarm_in,
  output hpsi_reg_req_t    reg_req,
  input  wire logic [7:0]  reg_rdata,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  hpsi_decode_t               dec;
  hpsi_state_t                state;
  hpsi_state_t                next_state;
  logic                       respond;
  logic                       next_respond;
  logic                       is_read;
  logic                       next_is_read;
  logic [7:0]                 next_data_out;
  logic                       hclk_prev;
  logic                       hclk_rise;
  logic                       strobe_rd;
  logic                       strobe_wr;
  logic                       strobe_end;
  logic                       host_rd_alarm;
  logic                       host_wr_global;
  logic                       rsvd_evt;
  logic                       access_evt;
  logic [7:0]                 alarm_prev;
  logic [7:0]                 next_alarm_prev;
  logic [7:0]                 alarm_chg;
  logic [7:0]                 next_alarm_chg;
  logic [7:0]                 alarm_change;
  logic                       global_irq_enable;
  logic                       next_gie;
  logic [EV_W-1:0]            irq_status;
  logic [EV_W-1:0]            next_irq_status;
  logic [EV_W-1:0]            irq_mask;
  logic [EV_W-1:0]            next_irq_mask;
  logic                       av_done;
  logic                       next_av_done;
  logic [31:0]                next_avs_readdata;
  logic                       av_req;
  logic                       av_mapped;
  logic                       av_wr_ctrl;
  logic                       av_wr_mask;
  logic                       av_rd_status;
  logic [RST_CNT_W-1:0]       rst_cnt;
  logic [RST_CNT_W-1:0]       next_rst_cnt;
  logic                       hw_clear;

  hpsi_addr_decode u_decode (
    .sel_n (sel_n),
    .upper (addr[10:8]),
    .dec   (dec)
  );

  // External selects follow the decode combinationally while selected
  assign ext_select_out_1_n = ~dec.ext_sel[0];
  assign ext_select_out_2_n = ~dec.ext_sel[1];
  assign ext_select_out_3_n = ~dec.ext_sel[2];
  assign ext_select_out_4_n = ~dec.ext_sel[3];
  assign ext_select_out_5_n = ~dec.ext_sel[4];

  // Hardware reset pin: only a low level held past the hold time clears state
  always_comb begin
    if (host_reset_n) begin
      next_rst_cnt = '0;
    end else if (rst_cnt == HW_RST_HOLD_CNT) begin
      next_rst_cnt = rst_cnt;
    end else begin
      next_rst_cnt = rst_cnt + RST_CNT_W'(1);
    end
    hw_clear = ~host_reset_n && (rst_cnt == HW_RST_HOLD_CNT);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rst_cnt <= '0;
    end else begin
      rst_cnt <= next_rst_cnt;
    end
  end

  // Protocol selection and strobe qualification
  assign hclk_rise = host_bus_clk & ~hclk_prev;

  always_comb begin
    strobe_rd  = 1'b0;
    strobe_wr  = 1'b0;
    strobe_end = 1'b1;
    case (host_type_select)
      HT_ASYNC_STROBE: begin
        strobe_rd  = ~hp_rd_we;
        strobe_wr  = ~hp_wr_rw;
        strobe_end = hp_rd_we & hp_wr_rw;
      end
      HT_ASYNC_DS: begin
        strobe_rd  = ~hp_rd_we & hp_wr_rw;
        strobe_wr  = ~hp_rd_we & ~hp_wr_rw;
        strobe_end = hp_rd_we;
      end
      HT_SYNC: begin
        // Transfer start is sampled on a host clock edge; the access
        // then lasts until the following host clock edge.
        strobe_rd  = hclk_rise & addr_latch_xfer_start & hp_wr_rw;
        strobe_wr  = hclk_rise & addr_latch_xfer_start & ~hp_wr_rw;
        strobe_end = hclk_rise;
      end
      default: begin
        // Undefined host types leave the port dead rather than guessing
        strobe_rd  = 1'b0;
        strobe_wr  = 1'b0;
        strobe_end = 1'b1;
      end
    endcase
  end

  // Host access state machine
  always_comb begin
    next_state     = state;
    next_respond   = respond;
    next_is_read   = is_read;
    next_data_out  = data_out;
    reg_req        = '0;
    host_rd_alarm  = 1'b0;
    host_wr_global = 1'b0;
    rsvd_evt       = 1'b0;
    access_evt     = 1'b0;
    case (state)
      ST_IDLE: begin
        if (!sel_n && !hw_clear && (strobe_rd || strobe_wr)) begin
          next_state   = ST_HOLD;
          next_is_read = strobe_rd;
          next_respond = dec.self_sel;
          rsvd_evt     = dec.reserved;
          if (dec.self_sel) begin
            access_evt = 1'b1;
            case (addr[7:0])
              HP_IDX_GLOBAL: begin
                host_wr_global = strobe_wr;
                next_data_out  = {7'h00, global_irq_enable};
              end
              HP_IDX_ALARM: begin
                host_rd_alarm  = strobe_rd;
                next_data_out  = alarm_chg;
              end
              default: begin
                reg_req.idx   = addr[7:0];
                reg_req.wdata = data_in;
                reg_req.rd    = strobe_rd;
                reg_req.wr    = strobe_wr;
                next_data_out = reg_rdata;
              end
            endcase
          end
        end
      end
      ST_HOLD: begin
        if (sel_n || strobe_end) begin
          next_state   = ST_IDLE;
          next_respond = 1'b0;
        end
      end
      default: begin
        next_state   = ST_IDLE;
        next_respond = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      respond   <= 1'b0;
      is_read   <= 1'b0;
      data_out  <= 8'h00;
      hclk_prev <= 1'b0;
    end else begin
      state     <= next_state;
      respond   <= next_respond;
      is_read   <= next_is_read;
      data_out  <= next_data_out;
      hclk_prev <= host_bus_clk;
    end
  end

  // Acknowledge and data drive only for accesses this device answers
  assign access_done_ack = (state == ST_HOLD) && respond && !sel_n;
  assign data_oe_n       = ~((state == ST_HOLD) && respond && is_read && !sel_n);

  // Alarm change capture and global enable
  always_comb begin
    alarm_change    = alarm_in ^ alarm_prev;
    next_alarm_prev = alarm_in;
    // Clear only what the host was shown, so a change in the same cycle survives
    next_alarm_chg  = (alarm_chg & ~(host_rd_alarm ? alarm_chg : 8'h00)) | alarm_change;
    next_gie        = global_irq_enable;
    if (host_wr_global) begin
      next_gie = data_in[GLB_GIE_BIT];
    end else if (av_wr_ctrl) begin
      next_gie = avs_writedata[GLB_GIE_BIT];
    end
    if (hw_clear) begin
      next_alarm_chg = ALARM_CHG_RST;
      next_gie       = GIE_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarm_prev <= 8'h00;
      alarm_chg  <= ALARM_CHG_RST;
      global_irq_enable        <= GIE_RST;
    end else begin
      alarm_prev <= next_alarm_prev;
      alarm_chg  <= next_alarm_chg;
      global_irq_enable        <= next_gie;
    end
  end

  // Open-drain interrupt pin: pull low while an enabled change is pending
  assign host_irq_out  = 1'b0;
  assign host_irq_oe_n = ~(global_irq_enable && (alarm_chg != 8'h00));

  // Avalon-MM slave: one wait cycle, then the access completes
  assign av_req          = avs_read | avs_write;
  assign avs_waitrequest = av_req & ~av_done;
  assign av_mapped       = (avs_address[1:0] == 2'b00);
  assign av_wr_ctrl      = avs_write && av_done && (avs_address == AV_CTRL);
  assign av_wr_mask      = avs_write && av_done && (avs_address == AV_IRQ_MASK);
  assign av_rd_status    = avs_read && av_done && (avs_address == AV_IRQ_STATUS);

  always_comb begin
    next_av_done      = av_req & ~av_done;
    next_avs_readdata = avs_readdata;
    if (avs_read && !av_done) begin
      next_avs_readdata = 32'h0000_0000;
      if (av_mapped) begin
        case (avs_address)
          AV_CTRL:        next_avs_readdata = {31'h0, global_irq_enable};
          AV_IRQ_STATUS:  next_avs_readdata = {29'h0, irq_status};
          AV_IRQ_MASK:    next_avs_readdata = {29'h0, irq_mask};
          AV_PORT_STATUS: next_avs_readdata = {22'h0, respond, hw_clear,
                                               ~host_irq_oe_n, host_type_select,
                                               addr[10:8], 1'b0};
          default:        next_avs_readdata = 32'h0000_0000;
        endcase
      end
    end
    next_irq_mask = av_wr_mask ? avs_writedata[EV_W-1:0] : irq_mask;
    // Read clears reported bits; an event in the same cycle still sets
    next_irq_status = irq_status & ~(av_rd_status ? avs_readdata[EV_W-1:0] : IRQ_STATUS_RST);
    next_irq_status[EV_ALARM]  = next_irq_status[EV_ALARM] | (alarm_change != 8'h00);
    next_irq_status[EV_RSVD]   = next_irq_status[EV_RSVD] | rsvd_evt;
    next_irq_status[EV_ACCESS] = next_irq_status[EV_ACCESS] | access_evt;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      av_done      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      irq_status   <= IRQ_STATUS_RST;
      irq_mask     <= IRQ_MASK_RST;
    end else begin
      av_done      <= next_av_done;
      avs_readdata <= next_avs_readdata;
      irq_status   <= next_irq_status;
      irq_mask     <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule

//--- hpsi_pkg.sv
/*
  Shared constants and types for the host port select and interrupt block.
  Assumes a single 40 MHz clock; all host pins are already synchronous to it.
*/
package hpsi_pkg;

  // Clock and hardware reset timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int HW_RST_HOLD_NS  = 10000;
  localparam int HW_RST_HOLD_CYC = (HW_RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W       = 9;
  localparam logic [RST_CNT_W-1:0] HW_RST_HOLD_CNT = RST_CNT_W'(HW_RST_HOLD_CYC);

  // Host bus protocol codes
  localparam logic [2:0] HT_ASYNC_STROBE = 3'h0;
  localparam logic [2:0] HT_ASYNC_DS     = 3'h1;
  localparam logic [2:0] HT_SYNC         = 3'h7;

  // Upper address decode codes
  localparam logic [2:0] UC_SELF     = 3'h0;
  localparam logic [2:0] UC_EXT1     = 3'h1;
  localparam logic [2:0] UC_EXT2     = 3'h2;
  localparam logic [2:0] UC_EXT3     = 3'h3;
  localparam logic [2:0] UC_EXT4     = 3'h4;
  localparam logic [2:0] UC_EXT5     = 3'h5;
  localparam logic [2:0] UC_RESERVED = 3'h6;
  localparam logic [2:0] UC_ALL      = 3'h7;
  localparam int         NUM_EXT_SEL = 5;

  // Register indices handled inside the port itself
  localparam logic [7:0] HP_IDX_GLOBAL = 8'he0;
  localparam logic [7:0] HP_IDX_ALARM  = 8'he1;
  localparam int         GLB_GIE_BIT   = 0;

  // Avalon-MM byte offsets
  localparam logic [3:0] AV_CTRL        = 4'h0;
  localparam logic [3:0] AV_IRQ_STATUS  = 4'h4;
  localparam logic [3:0] AV_IRQ_MASK    = 4'h8;
  localparam logic [3:0] AV_PORT_STATUS = 4'hc;

  // Event bits of the Avalon status and mask registers
  localparam int EV_ALARM  = 0;
  localparam int EV_RSVD   = 1;
  localparam int EV_ACCESS = 2;
  localparam int EV_W      = 3;

  // Reset values
  localparam logic [7:0]      ALARM_CHG_RST  = 8'h00;
  localparam logic [EV_W-1:0] IRQ_STATUS_RST = 3'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST   = 3'h0;
  localparam logic            GIE_RST        = 1'b0;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wdata;
    logic       rd;
    logic       wr;
  } hpsi_reg_req_t;

  typedef struct packed {
    logic                   self_sel;
    logic                   reserved;
    logic [NUM_EXT_SEL-1:0] ext_sel;
  } hpsi_decode_t;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_HOLD
  } hpsi_state_t;

endpackage

//--- hpsi_props.sv
/*
  Concurrent checks on the host port select and interrupt block.
  Assumes it is bound to hpsi_host_port and sees only its ports.
*/
`timescale 1ns/100ps
module hpsi_props
  import hpsi_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          host_reset_n,
  input wire logic          sel_n,
  input wire logic [10:0]   addr,
  input wire logic [7:0]    data_in,
  input wire logic          hp_wr_rw,
  input wire logic          hp_rd_we,
  input wire logic          addr_latch_xfer_start,
  input wire logic          host_bus_clk,
  input wire logic [2:0]    host_type_select,
  input wire logic          data_oe_n,
  input wire logic          access_done_ack,
  input wire logic          ext_select_out_1_n,
  input wire logic          ext_select_out_2_n,
  input wire logic          ext_select_out_3_n,
  input wire logic          ext_select_out_4_n,
  input wire logic          ext_select_out_5_n,
  input hpsi_reg_req_t      reg_req
);
  wire [4:0] ext_n = {ext_select_out_5_n, ext_select_out_4_n, ext_select_out_3_n,
                      ext_select_out_2_n, ext_select_out_1_n};
  wire [2:0] uc    = addr[10:8];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_start;
    host_type_select == HT_ASYNC_STROBE && host_reset_n && !sel_n && uc == UC_SELF
      && hp_wr_rw && $fell(hp_rd_we);
  endsequence
  sequence s_sync_start;
    host_type_select == HT_SYNC && host_reset_n && !sel_n && uc == UC_SELF
      && addr_latch_xfer_start && $rose(host_bus_clk);
  endsequence
  sequence s_wr_start;
    host_type_select == HT_ASYNC_STROBE && host_reset_n && !sel_n && uc == UC_SELF
      && hp_rd_we && $fell(hp_wr_rw);
  endsequence

  chk_sel_quiet: assert property (
    sel_n |-> ext_n == 5'h1f && !access_done_ack && data_oe_n) else $error("busy while idle");
  chk_self_only: assert property (
    !sel_n && uc == UC_SELF |-> ext_n == 5'h1f) else $error("select out on self code");
  chk_ext_onehot: assert property (
    !sel_n && uc inside {[UC_EXT1:UC_EXT5]} |-> ext_n == ~(5'h01 << (uc - 3'h1))
      && !access_done_ack) else $error("bad one-hot select");
  chk_bcast_all: assert property (
    !sel_n && uc == UC_ALL |-> ext_n == 5'h00) else $error("broadcast incomplete");
  chk_rsvd_none: assert property (
    !sel_n && uc == UC_RESERVED |-> ext_n == 5'h1f && !access_done_ack)
    else $error("reserved code answered");
  chk_rd_ack: assert property (
    s_rd_start |=> access_done_ack && !data_oe_n) else $error("read not acknowledged");
  chk_idx_direct: assert property (
    s_rd_start and (addr[7:0] != HP_IDX_GLOBAL && addr[7:0] != HP_IDX_ALARM)
      |-> reg_req.rd && reg_req.idx == addr[7:0]) else $error("index not forwarded");
  chk_wr_forward: assert property (
    s_wr_start and (addr[7:0] != HP_IDX_GLOBAL && addr[7:0] != HP_IDX_ALARM)
      |-> reg_req.wr && !reg_req.rd && reg_req.idx == addr[7:0] && reg_req.wdata == data_in)
    else $error("write not forwarded");
  chk_oe_reads: assert property (
    !data_oe_n |-> !sel_n && access_done_ack && hp_wr_rw) else $error("data driven off read");
  chk_sync_ack: assert property (
    s_sync_start |-> ##[1:2] access_done_ack) else $error("sync access not acked");
endmodule

bind hpsi_host_port hpsi_props i_props (
  .clk(clk), .rst_n(rst_n), .host_reset_n(host_reset_n), .sel_n(sel_n), .addr(addr),
  .data_in(data_in),
  .hp_wr_rw(hp_wr_rw), .hp_rd_we(hp_rd_we), .addr_latch_xfer_start(addr_latch_xfer_start),
  .host_bus_clk(host_bus_clk), .host_type_select(host_type_select), .data_oe_n(data_oe_n),
  .access_done_ack(access_done_ack), .ext_select_out_1_n(ext_select_out_1_n),
  .ext_select_out_2_n(ext_select_out_2_n), .ext_select_out_3_n(ext_select_out_3_n),
  .ext_select_out_4_n(ext_select_out_4_n), .ext_select_out_5_n(ext_select_out_5_n),
  .reg_req(reg_req));

//--- tb_top.sv
/*
  Self-checking bench for hpsi_host_port: host port, interrupts, Avalon-MM.
  Assumes hpsi_host_model as the host and the bound checker.
*/
`timescale 1ns/100ps
module tb_top
  import hpsi_pkg::*;
;
  logic        clk, rst_n, host_reset_n, sel_n, hp_wr_rw, hp_rd_we, xs, hbc, got;
  logic        data_oe_n, ack, irq_out, irq_oe_n, avs_read, avs_write, wreq, irq, int_pin;
  logic [10:0] addr;
  logic [7:0]  data_in, data_out, alarm_in, reg_rdata, rdat;
  logic [2:0]  hts;
  logic [4:0]  ext_n, seen;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  hpsi_reg_req_t reg_req;
  int          err_total, n_checks;

  hpsi_host_port i_dut (
    .clk(clk), .rst_n(rst_n), .host_reset_n(host_reset_n), .sel_n(sel_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .hp_wr_rw(hp_wr_rw),
    .hp_rd_we(hp_rd_we), .addr_latch_xfer_start(xs), .host_bus_clk(hbc),
    .host_type_select(hts), .access_done_ack(ack), .host_irq_out(irq_out),
    .host_irq_oe_n(irq_oe_n), .ext_select_out_1_n(ext_n[0]), .ext_select_out_2_n(ext_n[1]),
    .ext_select_out_3_n(ext_n[2]), .ext_select_out_4_n(ext_n[3]),
    .ext_select_out_5_n(ext_n[4]), .alarm_in(alarm_in), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(wreq), .irq(irq));

  hpsi_host_model i_host (
    .clk(clk), .data_out(data_out), .data_oe_n(data_oe_n), .access_done_ack(ack),
    .ext_n(ext_n), .host_irq_out(irq_out), .host_irq_oe_n(irq_oe_n), .sel_n(sel_n),
    .addr(addr), .data_in(data_in), .hp_wr_rw(hp_wr_rw), .hp_rd_we(hp_rd_we),
    .addr_latch_xfer_start(xs), .host_bus_clk(hbc), .host_type_select(hts),
    .int_pin(int_pin));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic av_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic av_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic hw(input logic [2:0] m, input logic [10:0] a, input logic [7:0] wd,
                    input logic rd);
    i_host.acc(m, a, wd, rd, 1'b1, rdat, got, seen);
  endtask

  task automatic t_reset();
    logic [3:0] ofs [4] = '{AV_CTRL, AV_IRQ_STATUS, AV_IRQ_MASK, 4'h2};
    for (int k = 0; k < 4; k++) begin
      av_rd(ofs[k], d);
      chk(d, 32'h0);
    end
    av_rd(AV_PORT_STATUS, d);
    chk(32'(d[6:4]), 32'(HT_ASYNC_STROBE));
    chk(32'(irq), 32'h0);
    chk(32'(int_pin), 32'h1);
    $display("reset test done");
  endtask

  task automatic t_decode();
    for (int c = 0; c < 8; c++) begin
      hw(HT_ASYNC_STROBE, {3'(c), 8'h10}, 8'h00, 1'b1);
      chk(32'(seen), (c == 0 || c == 6) ? 32'h1f : (c == 7) ? 32'h0 :
          (~(32'h1 << (c - 1)) & 32'h1f));
      chk(32'(got), 32'(c == 0 || c == 7));
      if (got === 1'b1) chk(32'(rdat), 32'h5a);
    end
    // Forwarded write; the checker compares index and data on the request
    hw(HT_ASYNC_STROBE, {UC_SELF, 8'h22}, 8'ha5, 1'b0);
    chk(32'(got), 32'h1);
    i_host.acc(HT_ASYNC_STROBE, {UC_SELF, 8'h10}, 8'h00, 1'b1, 1'b0, rdat, got, seen);
    chk(32'(got), 32'h0);
    chk(32'(seen), 32'h1f);
    av_rd(AV_IRQ_STATUS, d);
    chk(32'(d[EV_RSVD]), 32'h1);
    chk(32'(d[EV_ACCESS]), 32'h1);
    av_rd(AV_IRQ_STATUS, d);
    chk(d, 32'h0);
    $display("decode test done");
  endtask

  task automatic t_irq();
    hw(HT_ASYNC_STROBE, {UC_SELF, HP_IDX_GLOBAL}, 8'h00, 1'b0);
    @(posedge clk);
    alarm_in <= 8'h0f;
    repeat (3) @(negedge clk);
    chk(32'(int_pin), 32'h1);
    hw(HT_ASYNC_STROBE, {UC_SELF, HP_IDX_ALARM}, 8'h00, 1'b1);
    chk(32'(rdat), 32'h0f);
    hw(HT_ASYNC_STROBE, {UC_SELF, HP_IDX_GLOBAL}, 8'h01, 1'b0);
    @(posedge clk);
    alarm_in <= 8'h3f;
    repeat (3) @(negedge clk);
    chk(32'(int_pin), 32'h0);
    hw(HT_ASYNC_STROBE, {UC_SELF, HP_IDX_ALARM}, 8'h00, 1'b1);
    chk(32'(rdat), 32'h30);
    chk(32'(int_pin), 32'h1);
    av_rd(AV_CTRL, d);
    chk(32'(d[0]), 32'h1);
    chk(32'(irq), 32'h0);
    av_wr(AV_IRQ_MASK, 32'h1);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h1);
    av_rd(AV_IRQ_STATUS, d);
    chk(32'(d[EV_ALARM]), 32'h1);
    repeat (2) @(negedge clk);
    chk(32'(irq), 32'h0);
    av_wr(AV_IRQ_MASK, 32'h0);
    $display("irq test done");
  endtask

  task automatic t_modes();
    logic [2:0] ml [3] = '{HT_ASYNC_STROBE, HT_ASYNC_DS, HT_SYNC};
    for (int k = 0; k < 3; k++) begin
      for (int v = 0; v < 2; v++) begin
        hw(ml[k], {UC_SELF, HP_IDX_GLOBAL}, 8'(v), 1'b0);
        chk(32'(got), 32'h1);
        hw(ml[k], {UC_SELF, HP_IDX_GLOBAL}, 8'h00, 1'b1);
        chk(32'(rdat[GLB_GIE_BIT]), 32'(v));
      end
    end
    hw(3'h3, {UC_SELF, 8'h10}, 8'h00, 1'b1);
    chk(32'(got), 32'h0);
    $display("modes test done");
  endtask

  task automatic t_hwreset();
    // A short pulse must leave the enable set; only the long one clears it
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      host_reset_n <= 1'b0;
      repeat (k ? 410 : 100) @(posedge clk);
      host_reset_n <= 1'b1;
      hw(HT_ASYNC_STROBE, {UC_SELF, HP_IDX_GLOBAL}, 8'h00, 1'b1);
      chk(32'(rdat[GLB_GIE_BIT]), 32'(k == 0));
    end
    $display("hw reset test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    host_reset_n = 1'b1;
    alarm_in = 8'h00;
    reg_rdata = 8'h5a;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    err_total = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_decode();
    t_irq();
    t_modes();
    t_hwreset();
    end_of_test();
  end
endmodule
